// file: hw/uart_holding_fifos_ctrl.sv
// Character path of one UART channel: shifters, holding FIFOs and FIFO control.
`timescale 1ns/100ps
module uart_holding_fifos_ctrl #(
    parameter int DEPTH         = uart_fifo_pkg::FIFO_DEPTH,
    parameter int CLKS_PER_TICK = uart_fifo_pkg::CLKS_PER_TICK
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Host parallel bus
    input  wire logic       bus_cs,
    input  wire logic       bus_rd,
    input  wire logic       bus_wr,
    input  wire logic [2:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    output logic      [1:0] rx_err_status,
    // Serial line
    input  wire logic       rx_in,
    output logic            tx_out,
    // DMA signalling and status
    output logic            rx_ready_n,
    output logic            tx_ready_n,
    output logic            rx_overrun
);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int DIV_W = $clog2(CLKS_PER_TICK + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [7:0]                 line_fmt_q, line_fmt_d, enh_feat_q, enh_feat_d;
    uart_fifo_pkg::fifo_ctrl_t  ctrl_q, ctrl_d;
    logic [7:0]                 rdata_q, rdata_d, last_q, last_d;
    logic [1:0]                 rerr_q, rerr_d, last_err_q, last_err_d;
    logic                       normal_acc, enh_acc, wr_hold, rd_hold, wr_ctrl;
    logic                       rx_flush, tx_flush;

    // FIFO connections.
    uart_fifo_pkg::rx_entry_t   rx_push_entry, rx_head;
    logic                       rx_push, rx_in_ready, rx_valid, rx_pop;
    logic                       tx_valid, tx_take;
    logic [7:0]                 tx_head;
    logic [CNT_W-1:0]           rx_count, tx_count, tx_free;
    logic [CNT_W-1:0]           rx_level, tx_level;

    // Oversampling divider.
    logic [DIV_W-1:0]           div_q, div_d;
    logic                       tick;

    // Receive shifter.
    uart_fifo_pkg::ser_state_t  rxs_q, rxs_d;
    logic [3:0]                 rsc_q, rsc_d;
    logic [2:0]                 rbit_q, rbit_d;
    logic [7:0]                 rsh_q, rsh_d;
    logic                       rdone_q, rdone_d;
    uart_fifo_pkg::rx_entry_t   rent_q, rent_d;

    // Transmit shifter.
    uart_fifo_pkg::ser_state_t  txs_q, txs_d;
    logic [3:0]                 tsc_q, tsc_d;
    logic [2:0]                 tbit_q, tbit_d;
    logic [7:0]                 tsh_q, tsh_d;
    logic                       tx_out_q, tx_out_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Register access decode and FIFO control.
    always_comb
    begin
        normal_acc = !line_fmt_q[uart_fifo_pkg::FMT_DIV_BIT];
        enh_acc    = line_fmt_q == uart_fifo_pkg::FMT_ENH_KEY;
        wr_hold    = bus_cs && bus_wr && normal_acc && bus_addr == uart_fifo_pkg::ADDR_HOLD;
        rd_hold    = bus_cs && bus_rd && normal_acc && bus_addr == uart_fifo_pkg::ADDR_HOLD;
        wr_ctrl    = bus_cs && bus_wr && normal_acc && bus_addr == uart_fifo_pkg::ADDR_CTRL;
        line_fmt_d = line_fmt_q;
        enh_feat_d = enh_feat_q;
        ctrl_d     = ctrl_q;
        if (bus_cs && bus_wr && bus_addr == uart_fifo_pkg::ADDR_FMT)
            line_fmt_d = bus_wdata;
        if (bus_cs && bus_wr && enh_acc && bus_addr == uart_fifo_pkg::ADDR_FEAT)
            enh_feat_d = bus_wdata;
        if (wr_ctrl)
        begin
            ctrl_d.fifo_en  = bus_wdata[uart_fifo_pkg::CTRL_EN_BIT];
            ctrl_d.dma_mode = bus_wdata[uart_fifo_pkg::CTRL_DMA_BIT];
            ctrl_d.rx_trig  = bus_wdata[uart_fifo_pkg::CTRL_RXTRIG_LSB +: 2];
            if (enh_feat_q[uart_fifo_pkg::FEAT_ENH_BIT])
                ctrl_d.tx_trig = bus_wdata[uart_fifo_pkg::CTRL_TXTRIG_LSB +: 2];
        end
        // Clear bits are never stored, so they fall back to zero by themselves.
        // A change of enable also flushes, since entry order differs per mode.
        rx_flush = wr_ctrl && (bus_wdata[uart_fifo_pkg::CTRL_RXCLR_BIT]
                   || bus_wdata[uart_fifo_pkg::CTRL_EN_BIT] != ctrl_q.fifo_en);
        tx_flush = wr_ctrl && (bus_wdata[uart_fifo_pkg::CTRL_TXCLR_BIT]
                   || bus_wdata[uart_fifo_pkg::CTRL_EN_BIT] != ctrl_q.fifo_en);
    end

    // Read data path; the control register address reads as zero, or as the feature register while the format holds 8'hbf.
    always_comb
    begin
        rx_pop     = rd_hold && rx_valid;
        last_d     = rx_pop ? rx_head.data : last_q;
        last_err_d = rx_pop ? {rx_head.brk, rx_head.frame_err} : last_err_q;
        rdata_d    = rdata_q;
        rerr_d     = rerr_q;
        if (bus_cs && bus_rd)
        begin
            rdata_d = 8'h00;
            if (rd_hold)
            begin
                rdata_d = last_d;
                rerr_d  = last_err_d;
            end
            else if (bus_addr == uart_fifo_pkg::ADDR_FMT)
                rdata_d = line_fmt_q;
            else if (enh_acc && bus_addr == uart_fifo_pkg::ADDR_FEAT)
                rdata_d = enh_feat_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            line_fmt_q <= uart_fifo_pkg::FMT_RESET;
            enh_feat_q <= uart_fifo_pkg::FEAT_RESET;
            ctrl_q     <= '0;
            rdata_q    <= 8'h00;
            rerr_q     <= 2'h0;
            last_q     <= 8'h00;
            last_err_q <= 2'h0;
        end
        else
        begin
            line_fmt_q <= line_fmt_d;
            enh_feat_q <= enh_feat_d;
            ctrl_q     <= ctrl_d;
            rdata_q    <= rdata_d;
            rerr_q     <= rerr_d;
            last_q     <= last_d;
            last_err_q <= last_err_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Holding FIFOs.
    char_fifo #(.WIDTH($bits(uart_fifo_pkg::rx_entry_t)), .DEPTH(DEPTH)) u_rx_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .flush     (rx_flush),
        .single    (!ctrl_q.fifo_en),
        .overwrite (1'b1),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (rx_push_entry),
        .out_valid (rx_valid),
        .out_ready (rx_pop),
        .out_data  (rx_head),
        .count     (rx_count)
    );

    char_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .flush     (tx_flush),
        .single    (!ctrl_q.fifo_en),
        .overwrite (1'b0),
        .in_valid  (wr_hold),
        .in_ready  (),
        .in_data   (bus_wdata),
        .out_valid (tx_valid),
        .out_ready (tx_take),
        .out_data  (tx_head),
        .count     (tx_count)
    );

    // DMA signalling; without FIFOs both modes behave as mode 0.
    always_comb
    begin
        rx_push       = rdone_q;
        rx_push_entry = rent_q;
        rx_overrun    = rdone_q && !rx_in_ready;
        case (ctrl_q.rx_trig)
            2'h0:    rx_level = CNT_W'(uart_fifo_pkg::RX_TRIG_0);
            2'h1:    rx_level = CNT_W'(uart_fifo_pkg::RX_TRIG_1);
            2'h2:    rx_level = CNT_W'(uart_fifo_pkg::RX_TRIG_2);
            default: rx_level = CNT_W'(uart_fifo_pkg::RX_TRIG_3);
        endcase
        case (ctrl_q.tx_trig)
            2'h0:    tx_level = CNT_W'(uart_fifo_pkg::TX_TRIG_0);
            2'h1:    tx_level = CNT_W'(uart_fifo_pkg::TX_TRIG_1);
            2'h2:    tx_level = CNT_W'(uart_fifo_pkg::TX_TRIG_2);
            default: tx_level = CNT_W'(uart_fifo_pkg::TX_TRIG_3);
        endcase
        tx_free = CNT_W'(DEPTH) - tx_count;
        if (ctrl_q.fifo_en && ctrl_q.dma_mode)
        begin
            rx_ready_n = !(rx_count >= rx_level);
            tx_ready_n = !(tx_free >= tx_level);
        end
        else
        begin
            rx_ready_n = rx_count == '0;
            tx_ready_n = tx_count != '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sixteen-times oversampling tick shared by both shifters.
    always_comb
    begin
        tick  = div_q == DIV_W'(CLKS_PER_TICK - 1);
        div_d = tick ? '0 : div_q + DIV_W'(1);
    end

    // Receive shifter: start bit checked at mid-bit, then one sample per bit time.
    always_comb
    begin
        rxs_d   = rxs_q;
        rsc_d   = rsc_q;
        rbit_d  = rbit_q;
        rsh_d   = rsh_q;
        rdone_d = 1'b0;
        rent_d  = rent_q;
        if (tick)
        begin
            rsc_d = rsc_q + 4'h1;
            case (rxs_q)
                uart_fifo_pkg::SER_IDLE:
                begin
                    rsc_d = 4'h0;
                    if (!rx_in)
                        rxs_d = uart_fifo_pkg::SER_START;
                end
                uart_fifo_pkg::SER_START:
                    if (rsc_q == uart_fifo_pkg::SAMPLE_MID)
                    begin
                        rsc_d  = 4'h0;
                        rbit_d = 3'h0;
                        rxs_d  = rx_in ? uart_fifo_pkg::SER_IDLE : uart_fifo_pkg::SER_DATA;
                    end
                uart_fifo_pkg::SER_DATA:
                    if (rsc_q == uart_fifo_pkg::OVERSAMPLE_LAST)
                    begin
                        rsh_d  = {rx_in, rsh_q[7:1]};
                        rbit_d = rbit_q + 3'h1;
                        if (rbit_q == 3'h7)
                            rxs_d = uart_fifo_pkg::SER_STOP;
                    end
                uart_fifo_pkg::SER_STOP:
                    if (rsc_q == uart_fifo_pkg::OVERSAMPLE_LAST)
                    begin
                        rdone_d          = 1'b1;
                        rent_d.data      = rsh_q;
                        rent_d.frame_err = !rx_in;
                        rent_d.brk       = !rx_in && rsh_q == 8'h00;
                        rxs_d            = uart_fifo_pkg::SER_IDLE;
                    end
                default:
                    rxs_d = uart_fifo_pkg::SER_IDLE;
            endcase
        end
    end

    // Transmit shifter pulls the next character only when idle, stalling the FIFO.
    always_comb
    begin
        txs_d    = txs_q;
        tsc_d    = tsc_q;
        tbit_d   = tbit_q;
        tsh_d    = tsh_q;
        tx_out_d = tx_out_q;
        tx_take  = txs_q == uart_fifo_pkg::SER_IDLE && tx_valid;
        case (txs_q)
            uart_fifo_pkg::SER_IDLE:
            begin
                tx_out_d = 1'b1;
                if (tx_take)
                begin
                    tsh_d    = tx_head;
                    tsc_d    = 4'h0;
                    tx_out_d = 1'b0;
                    txs_d    = uart_fifo_pkg::SER_START;
                end
            end
            uart_fifo_pkg::SER_START, uart_fifo_pkg::SER_DATA, uart_fifo_pkg::SER_STOP:
                if (tick)
                begin
                    tsc_d = tsc_q + 4'h1;
                    if (tsc_q == uart_fifo_pkg::OVERSAMPLE_LAST)
                    begin
                        if (txs_q == uart_fifo_pkg::SER_START)
                        begin
                            tbit_d   = 3'h0;
                            tx_out_d = tsh_q[0];
                            txs_d    = uart_fifo_pkg::SER_DATA;
                        end
                        else if (txs_q == uart_fifo_pkg::SER_DATA)
                        begin
                            tsh_d    = {1'b1, tsh_q[7:1]};
                            tbit_d   = tbit_q + 3'h1;
                            tx_out_d = (tbit_q == 3'h7) ? 1'b1 : tsh_q[1];
                            if (tbit_q == 3'h7)
                                txs_d = uart_fifo_pkg::SER_STOP;
                        end
                        else
                            txs_d = uart_fifo_pkg::SER_IDLE;
                    end
                end
            default:
                txs_d = uart_fifo_pkg::SER_IDLE;
        endcase
    end

    // Shifters are untouched by FIFO clears; only reset returns them to idle.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            div_q    <= '0;
            rxs_q    <= uart_fifo_pkg::SER_IDLE;
            rsc_q    <= 4'h0;
            rbit_q   <= 3'h0;
            rsh_q    <= 8'h00;
            rdone_q  <= 1'b0;
            rent_q   <= '0;
            txs_q    <= uart_fifo_pkg::SER_IDLE;
            tsc_q    <= 4'h0;
            tbit_q   <= 3'h0;
            tsh_q    <= 8'h00;
            tx_out_q <= 1'b1;
        end
        else
        begin
            div_q    <= div_d;
            rxs_q    <= rxs_d;
            rsc_q    <= rsc_d;
            rbit_q   <= rbit_d;
            rsh_q    <= rsh_d;
            rdone_q  <= rdone_d;
            rent_q   <= rent_d;
            txs_q    <= txs_d;
            tsc_q    <= tsc_d;
            tbit_q   <= tbit_d;
            tsh_q    <= tsh_d;
            tx_out_q <= tx_out_d;
        end
    end

    always_comb
    begin
        bus_rdata     = rdata_q;
        rx_err_status = rerr_q;
        tx_out        = tx_out_q;
    end

endmodule

// file: hw/uart_fifo_pkg.sv
// Constants, field layouts and carrier types for the UART holding FIFO channel.
package uart_fifo_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int          FIFO_DEPTH      = 64;
    localparam int          CHAR_W          = 8;

    localparam logic [2:0]  ADDR_HOLD       = 3'h0;
    localparam logic [2:0]  ADDR_CTRL       = 3'h2;
    localparam logic [2:0]  ADDR_FEAT       = 3'h2;
    localparam logic [2:0]  ADDR_FMT        = 3'h3;

    localparam logic [7:0]  FMT_RESET       = 8'h00;
    localparam logic [7:0]  FEAT_RESET      = 8'h00;
    localparam logic [7:0]  FMT_ENH_KEY     = 8'hbf;
    localparam int          FMT_DIV_BIT     = 7;
    localparam int          FEAT_ENH_BIT    = 4;

    localparam int          CTRL_EN_BIT     = 0;
    localparam int          CTRL_RXCLR_BIT  = 1;
    localparam int          CTRL_TXCLR_BIT  = 2;
    localparam int          CTRL_DMA_BIT    = 3;
    localparam int          CTRL_TXTRIG_LSB = 4;
    localparam int          CTRL_RXTRIG_LSB = 6;

    localparam logic [6:0]  RX_TRIG_0       = 7'h08;
    localparam logic [6:0]  RX_TRIG_1       = 7'h10;
    localparam logic [6:0]  RX_TRIG_2       = 7'h38;
    localparam logic [6:0]  RX_TRIG_3       = 7'h3c;
    localparam logic [6:0]  TX_TRIG_0       = 7'h08;
    localparam logic [6:0]  TX_TRIG_1       = 7'h10;
    localparam logic [6:0]  TX_TRIG_2       = 7'h20;
    localparam logic [6:0]  TX_TRIG_3       = 7'h38;

    localparam int          CLK_HZ          = 125000000;
    localparam int          BAUD_RATE       = 115200;
    localparam logic [3:0]  OVERSAMPLE_LAST = 4'hf;
    localparam logic [3:0]  SAMPLE_MID      = 4'h7;
    localparam int          CLKS_PER_TICK   = CLK_HZ / (16 * BAUD_RATE);

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic               brk;
        logic               frame_err;
        logic [7:0]         data;
    } rx_entry_t;

    typedef struct packed {
        logic [1:0]         rx_trig;
        logic [1:0]         tx_trig;
        logic               dma_mode;
        logic               fifo_en;
    } fifo_ctrl_t;

    typedef enum logic [3:0] {
        SER_IDLE  = 4'h1,
        SER_START = 4'h2,
        SER_DATA  = 4'h4,
        SER_STOP  = 4'h8
    } ser_state_t;

endpackage

// file: hw/char_fifo.sv
// Character FIFO with flush and a single-entry holding mode.
`timescale 1ns/100ps
module char_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 64,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Mode control
    input  wire logic             flush,
    input  wire logic             single,
    input  wire logic             overwrite,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [CNT_W-1:0]      count
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [CNT_W-1:0] count_q, count_d;
    logic             full, push, pop;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        full      = single ? (count_q != '0) : (count_q == CNT_W'(DEPTH));
        in_ready  = !full || (single && overwrite);
        out_valid = count_q != '0;
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        out_data  = mem[rd_ptr_q];
        count     = count_q;
        wr_ptr_d  = wr_ptr_q;
        rd_ptr_d  = rd_ptr_q;
        count_d   = count_q;
        if (flush)
        begin
            wr_ptr_d = '0;
            rd_ptr_d = '0;
            count_d  = '0;
        end
        else if (single)
        begin
            // Only location zero is used, so the pointers stay parked there.
            wr_ptr_d = '0;
            rd_ptr_d = '0;
            if (push)
                count_d = CNT_W'(1);
            else if (pop)
                count_d = '0;
        end
        else
        begin
            if (push)
                wr_ptr_d = (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + PTR_W'(1);
            if (pop)
                rd_ptr_d = (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + PTR_W'(1);
            count_d = count_q + CNT_W'(push) - CNT_W'(pop);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // Storage is not cleared by a flush; the count alone marks it empty.
    always_ff @(posedge clk)
    begin
        if (push && !flush)
            mem[single ? '0 : wr_ptr_q] <= in_data;
    end

endmodule

// file: testbench/uart_hold_checker.sv
// Port-level assertions for the UART holding FIFO channel.
`timescale 1ns/100ps
module uart_hold_checker #(
    parameter int CLKS_PER_TICK = 1
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Host bus, status and serial line
    input wire logic       bus_cs,
    input wire logic       bus_rd,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_rdata,
    input wire logic [1:0] rx_err_status,
    input wire logic       tx_out,
    input wire logic       rx_ready_n,
    input wire logic       tx_ready_n,
    input wire logic       rx_overrun
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Counts consecutive low samples on the transmit line; frame widths are judged on it.
    logic [15:0] low_q;
    logic [15:0] low_d;
    always_comb low_d = tx_out ? 16'h0000 : low_q + 16'h0001;
    always_ff @(posedge clk) low_q <= reset_n ? low_d : 16'h0000;
    sequence s_read;
        bus_cs && bus_rd;
    endsequence
    sequence s_no_read;
        !(bus_cs && bus_rd);
    endsequence
    chk_reset_state: assert property ($rose(reset_n) |-> tx_out && rx_ready_n
        && !tx_ready_n && !rx_overrun && bus_rdata == 8'h00) else $error("bad reset state");
    chk_rdata_hold: assert property (s_no_read |=> $stable(bus_rdata))
        else $error("read data moved without a read");
    chk_err_hold: assert property (s_no_read |=> $stable(rx_err_status))
        else $error("error status moved without a read");
    chk_unmapped_zero: assert property (s_read ##0 (bus_addr == 3'h1 || bus_addr > 3'h3)
        |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
    chk_overrun_pulse: assert property (rx_overrun |=> !rx_overrun)
        else $error("overrun longer than one cycle");
    chk_overrun_ready: assert property (rx_overrun |-> !rx_ready_n)
        else $error("overrun while receive not ready");
    chk_start_len: assert property ($rose(tx_out) |-> low_q >= 16'h0010 * CLKS_PER_TICK)
        else $error("transmit low run shorter than a bit");
    chk_low_max: assert property (low_q <= 16'h0090 * CLKS_PER_TICK)
        else $error("transmit low run longer than a frame");
endmodule
bind uart_holding_fifos_ctrl uart_hold_checker #(.CLKS_PER_TICK(CLKS_PER_TICK)) u_chk (
    .clk(clk), .reset_n(reset_n), .bus_cs(bus_cs), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_rdata(bus_rdata), .rx_err_status(rx_err_status), .tx_out(tx_out),
    .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n), .rx_overrun(rx_overrun));

// file: testbench/serial_peer.sv
// Remote serial device: sends frames on rx_in and collects frames from tx_out.
`timescale 1ns/100ps
module serial_peer #(
    parameter int BIT_CLKS = 16
) (
    // Clock and serial line
    input wire logic clk,
    input wire logic tx_out,
    output logic     rx_in
);
    logic [7:0] got_q[$];
    logic [7:0] sh;
    // The line idles high between frames, as a pulled-up line would.
    initial rx_in = 1'b1;
    task automatic send(input logic [7:0] d, input logic stp);
        logic [10:0] f;
        f = {1'b1, stp, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk) rx_in <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clk);
        end
    endtask
    initial
    forever
    begin
        @(negedge tx_out);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CLKS) @(posedge clk);
            sh[i] = tx_out;
        end
        repeat (BIT_CLKS) @(posedge clk);
        got_q.push_back(sh);
    end
endmodule

// file: testbench/uart_holding_fifos_ctrl_tb_top.sv
// Self-checking bench for the UART holding FIFO channel.
`timescale 1ns/100ps
module uart_holding_fifos_ctrl_tb_top;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       bus_cs = 1'b0;
    logic       bus_rd = 1'b0;
    logic       bus_wr = 1'b0;
    logic [2:0] bus_addr = 3'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic [1:0] rx_err_status;
    logic       rx_in, tx_out, rx_ready_n, tx_ready_n, rx_overrun;
    int         overruns = 0;
    logic [6:0] trig [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};
    int         mismatches = 0;
    int         samples_checked = 0;
    always #4 clk = ~clk;
    // The overrun pulse lasts one cycle, so the falling edge sees it settled.
    always @(negedge clk)
        if (rx_overrun === 1'b1)
            overruns++;
    uart_holding_fifos_ctrl #(.CLKS_PER_TICK(1)) u_uart_holding_fifos_ctrl (
        .clk(clk), .reset_n(reset_n), .bus_cs(bus_cs), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .rx_err_status(rx_err_status), .rx_in(rx_in), .tx_out(tx_out),
        .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n), .rx_overrun(rx_overrun));
    serial_peer #(.BIT_CLKS(16)) u_serial_peer (.clk(clk), .tx_out(tx_out), .rx_in(rx_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) {bus_cs, bus_wr, bus_addr, bus_wdata} <= {2'b11, a, d};
        @(posedge clk) {bus_cs, bus_wr} <= 2'b00;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk) {bus_cs, bus_rd, bus_addr} <= {2'b11, a};
        @(posedge clk) {bus_cs, bus_rd} <= 2'b00;
        @(posedge clk) #1 check({2'b00, bus_rdata}, {2'b00, exp});
    endtask
    // Flags are looked at one edge late so that the last write has taken effect.
    task automatic rdy(input logic [1:0] exp);
        @(posedge clk) #1 check({8'h00, rx_ready_n, tx_ready_n}, {8'h00, exp});
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        wr(3'h2, 8'h01);
        u_serial_peer.send(8'h5a, 1'b1);
        u_serial_peer.send(8'ha5, 1'b0);
        wr(3'h3, 8'h80);
        rd(3'h0, 8'h00);
        wr(3'h3, 8'h00);
        rd(3'h0, 8'h5a);
        rd(3'h0, 8'ha5);
        check({8'h00, rx_err_status}, 10'h001);
        rd(3'h0, 8'ha5);
        rd(3'h2, 8'h00);
        rd(3'h5, 8'h00);
        u_serial_peer.send(8'h00, 1'b0);
        rd(3'h0, 8'h00);
        check({8'h00, rx_err_status}, 10'h003);
        u_serial_peer.send(8'h33, 1'b1);
        wr(3'h2, 8'h03);
        rdy(2'b10);
        rd(3'h0, 8'h00);
        wr(3'h2, 8'h00);
        u_serial_peer.send(8'h11, 1'b1);
        u_serial_peer.send(8'h22, 1'b1);
        rd(3'h0, 8'h22);
        rdy(2'b10);
        wr(3'h0, 8'h3c);
        repeat (2) @(posedge clk);
        wr(3'h0, 8'hc3);
        wr(3'h0, 8'h99);
        for (int n = 0; n < 600; n++) @(posedge clk);
        check(10'(u_serial_peer.got_q.size()), 10'h002);
        check({2'b00, u_serial_peer.got_q[0]}, 10'h03c);
        check({2'b00, u_serial_peer.got_q[1]}, 10'h0c3);
        for (int c = 0; c < 4; c++)
        begin
            wr(3'h2, {c[1:0], 6'h0b});
            repeat (trig[c] - 7'h01) u_serial_peer.send(8'h41, 1'b1);
            rdy(2'b10);
            u_serial_peer.send(8'h41, 1'b1);
            rdy(2'b00);
        end
        repeat (5) u_serial_peer.send(8'h41, 1'b1);
        check(10'(overruns), 10'h001);
        wr(3'h2, 8'h3f);
        repeat (50) wr(3'h0, 8'h55);
        rdy(2'b10);
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        rd(3'h2, 8'h10);
        wr(3'h3, 8'h00);
        wr(3'h2, 8'h3d);
        rdy(2'b10);
        repeat (10) wr(3'h0, 8'h55);
        rdy(2'b11);
        print_verdict();
    end
endmodule
